// File: hdab_pkg.sv
// Shared constants, register map and bus carrier for the half-duplex busy link.
package hdab_pkg;

  // Clock and line rate.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LINE_BPS = 9600;
  // The bit timer counts a prescaled clock up to this compare value.
  localparam int unsigned TIMER_COMPARE = 54;
  // Prescale chosen so that prescale times compare is one bit period (rounded down).
  localparam int unsigned TIMER_PRESCALE = CLK_HZ / (LINE_BPS * TIMER_COMPARE);

  // Frame shape: eight data bits, one parity bit, two stop bits.
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned SHIFT_BITS = 9;
  localparam int unsigned STOP_BITS = 2;
  // Cycles the line stays released before its level is taken.
  localparam logic [1:0] SAMPLE_WAIT = 2'h3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Control register fields.
  localparam int unsigned CTRL_ODD = 0;
  localparam int unsigned CTRL_TOGGLE = 1;
  localparam int unsigned CTRL_ARMED = 2;

  // Sticky event bits of the status and mask registers.
  localparam int unsigned EV_RX_DONE = 0;
  localparam int unsigned EV_PARITY = 1;
  localparam int unsigned EV_STOP = 2;
  localparam int unsigned EV_OVERRUN = 3;
  localparam int unsigned EV_TX_DONE = 4;
  localparam int unsigned EV_BITS = 5;
  // Live status bits above the sticky ones.
  localparam int unsigned ST_TX_BUSY = 8;
  localparam int unsigned ST_RX_FULL = 9;
  localparam int unsigned ST_PERR_LAST = 10;
  localparam int unsigned ST_SERR_LAST = 11;

  // Reset values.
  localparam logic [EV_BITS-1:0] MASK_RESET = 5'h00;

  // Register bus request carried as one bundle.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hdab_bus_req_s;

endpackage

// File: hdab_bit_timer.sv
// Bit-period timer: prescaler plus compare counter, restartable at full or half period.
`timescale 1ns/10ps
module hdab_bit_timer #(
  parameter int unsigned PRESCALE = 482,
  parameter int unsigned COMPARE = 54
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Control from the link engine.
  input wire logic restart_in,
  input wire logic half_in,
  // One-cycle pulse at the end of each period.
  output logic tick_out
);

  localparam int unsigned PW = $clog2(PRESCALE + 1);
  localparam int unsigned CW = $clog2(COMPARE + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  localparam logic [CW-1:0] CMP_LAST = CW'(COMPARE - 1);
  localparam logic [CW-1:0] CMP_HALF = CW'(COMPARE / 2);

  logic [PW-1:0] pre_ff;
  logic [CW-1:0] cmp_ff;
  logic pre_wrap;

  assign pre_wrap = (pre_ff == PRE_LAST);

  // A restart also clears the prescaler; the first period is whole, or half when half_in is set.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || restart_in) begin
      pre_ff <= '0;
      cmp_ff <= (!reset_in && half_in) ? CMP_HALF : '0;
    end else if (pre_wrap) begin
      pre_ff <= '0;
      cmp_ff <= (cmp_ff == CMP_LAST) ? '0 : cmp_ff + 1'b1;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // The tick is registered so the engine sees a clean one-cycle pulse.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || restart_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= pre_wrap && (cmp_ff == CMP_LAST);
    end
  end

endmodule

// File: hdab_link.sv
// Half-duplex asynchronous link engine with busy handshake and register port.
`timescale 1ns/10ps
// How it works
// - Transmission starts only while the synchronised peer busy input is low.
// - One shared line carries both directions; it is driven except during sampling and the release step after reset.
// - After the start bit nine bits go out: eight data then parity, then two stops.
// - The start bit is driven low for one whole timer period.
// - A falling start edge starts reception; start is accepted only if line still low.
// - Sampling releases the line, waits, takes the level, then drives again.
// - Frames end by counting bits, so a parity one still completes the frame.
// - After the second stop the shifter is disabled one cycle, then re-enabled.
// - Odd parity when the odd select bit is set, even otherwise.
// - Parity error flagged when received parity mismatches computed parity.
// - Both stop bits are sampled; any low sample flags a stop error.
// - Receive done only without errors; frame error flags cleared before checking.
// - Overrun flagged when a new frame starts before the last byte was read.
// - Busy output goes high once the nine received bits are complete.
// - A toggle write inverts busy; going low arms start-edge detection.
// - Bit timer runs at 9600 bit/s using compare value 54.
// - After reset: line high, release issued, then latch returned before any frame.
module hdab_link #(
  parameter int unsigned PRESCALE = hdab_pkg::TIMER_PRESCALE
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Register port.
  input wire hdab_pkg::hdab_bus_req_s bus_req_in,
  output logic [31:0] rdata_out,
  // Shared serial line, split into level, drive and enable (low = driving).
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n_out,
  // Busy handshake and start edge input.
  input wire logic peer_busy_in,
  input wire logic start_edge_input_in,
  output logic busy_out,
  // Interrupt.
  output logic irq_out
);

  typedef enum logic [3:0] {
    ST_INIT_HI, ST_INIT_REL, ST_INIT_LO, ST_IDLE, ST_TX_START, ST_TX_BITS, ST_TX_STOP,
    ST_RX_START, ST_RX_BITS, ST_RX_STOP, ST_REARM
  } hdab_state_e;

  hdab_state_e state_ff, nxt_state;
  logic [2:0] line_sync_ff, busy_sync_ff, edge_sync_ff;
  logic line_s, busy_s, edge_fall;
  logic tick, tmr_restart, tmr_half;
  logic [1:0] smp_cnt_ff;
  logic smp_now;
  logic [3:0] bit_cnt_ff;
  logic [8:0] shreg_ff;
  logic shift_en_ff, line_out_ff, line_oe_n_ff;
  logic odd_ff, busy_ff, armed_ff, tx_pend_ff, rx_full_ff;
  logic [7:0] tx_data_ff, rx_data_ff;
  logic perr_last_ff, serr_frame_ff, serr_last_ff;
  logic [hdab_pkg::EV_BITS-1:0] status_ff, mask_ff, ev_set, ev_clr;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic rx_fin, fin_perr, fin_serr, tx_fin, rx_nine, tx_go, rx_go;

  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction

  function automatic logic hit(input hdab_pkg::hdab_bus_req_s r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  hdab_bit_timer #(
    .PRESCALE(PRESCALE),
    .COMPARE(hdab_pkg::TIMER_COMPARE)
  ) u_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .restart_in(tmr_restart),
    .half_in(tmr_half),
    .tick_out(tick)
  );

  // Pins come from the far node; two flops before anything looks at them.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      line_sync_ff <= 3'h7;
      busy_sync_ff <= 3'h7;
      edge_sync_ff <= 3'h7;
    end else begin
      line_sync_ff <= {line_sync_ff[1:0], line_in};
      busy_sync_ff <= {busy_sync_ff[1:0], peer_busy_in};
      edge_sync_ff <= {edge_sync_ff[1:0], start_edge_input_in};
    end
  end

  assign line_s = line_sync_ff[1];
  assign busy_s = busy_sync_ff[1];
  assign edge_fall = edge_sync_ff[2] && !edge_sync_ff[1];
  assign smp_now = (smp_cnt_ff == 2'h1);

  assign tx_go = (state_ff == ST_IDLE) && tx_pend_ff && !busy_s && !edge_fall;
  assign rx_go = (state_ff == ST_IDLE) && armed_ff && edge_fall;
  assign rx_nine = (state_ff == ST_RX_BITS) && smp_now && (bit_cnt_ff == 4'(hdab_pkg::SHIFT_BITS - 1));
  assign tx_fin = (state_ff == ST_TX_STOP) && tick && (bit_cnt_ff == 4'(hdab_pkg::STOP_BITS - 1));
  assign rx_fin = (state_ff == ST_RX_STOP) && smp_now && (bit_cnt_ff == 4'(hdab_pkg::STOP_BITS - 1));
  assign fin_perr = par_of(shreg_ff[7:0], odd_ff) != shreg_ff[8];
  assign fin_serr = serr_frame_ff || !line_s;
  assign tmr_restart = tx_go || rx_go || (state_ff == ST_TX_START && tick);
  assign tmr_half = rx_go;

  // Next state; transmit phases move on a timer tick, receive phases on a sample; init and rearm steps take one cycle each.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_INIT_HI: nxt_state = ST_INIT_REL;
      ST_INIT_REL: nxt_state = ST_INIT_LO;
      ST_INIT_LO: nxt_state = ST_IDLE;
      ST_IDLE: begin
        if (rx_go) begin
          nxt_state = ST_RX_START;
        end else if (tx_go) begin
          nxt_state = ST_TX_START;
        end
      end
      ST_TX_START: if (tick) nxt_state = ST_TX_BITS;
      ST_TX_BITS: begin
        if (tick && bit_cnt_ff == 4'(hdab_pkg::SHIFT_BITS - 1)) begin
          nxt_state = ST_TX_STOP;
        end
      end
      ST_TX_STOP: if (tx_fin) nxt_state = ST_REARM;
      ST_RX_START: if (smp_now) nxt_state = line_s ? ST_IDLE : ST_RX_BITS;
      ST_RX_BITS: if (rx_nine) nxt_state = ST_RX_STOP;
      ST_RX_STOP: if (rx_fin) nxt_state = ST_REARM;
      ST_REARM: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_ff <= ST_INIT_HI;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter and shifter; both directions share one nine-bit register.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 9'h1ff;
    end else if (tx_go) begin
      shreg_ff <= {par_of(tx_data_ff, odd_ff), tx_data_ff};
      bit_cnt_ff <= 4'h0;
    end else if (rx_go || (state_ff == ST_TX_START && tick)) begin
      bit_cnt_ff <= 4'h0;
    end else if (state_ff == ST_TX_BITS && tick) begin
      shreg_ff <= {1'b1, shreg_ff[8:1]};
      bit_cnt_ff <= (bit_cnt_ff == 4'(hdab_pkg::SHIFT_BITS - 1)) ? 4'h0 : bit_cnt_ff + 4'h1;
    end else if (state_ff == ST_RX_BITS && smp_now) begin
      shreg_ff <= {line_s, shreg_ff[8:1]};
      bit_cnt_ff <= rx_nine ? 4'h0 : bit_cnt_ff + 4'h1;
    end else if ((state_ff == ST_TX_STOP && tick) || (state_ff == ST_RX_STOP && smp_now)) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // Sample window: release on the tick, take the level three cycles later.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      smp_cnt_ff <= 2'h0;
    end else if (tick && (state_ff == ST_RX_START || state_ff == ST_RX_BITS ||
                          state_ff == ST_RX_STOP)) begin
      smp_cnt_ff <= hdab_pkg::SAMPLE_WAIT;
    end else if (smp_cnt_ff != 2'h0) begin
      smp_cnt_ff <= smp_cnt_ff - 2'h1;
    end
  end

  // Line driver. Both ends drive high while idle, so the limitation is that a peer
  // sending while we drive high fights us; the window keeps that short.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      line_out_ff <= 1'b1;
      line_oe_n_ff <= 1'b0;
    end else begin
      line_oe_n_ff <= 1'b0;
      line_out_ff <= 1'b1;
      if (state_ff == ST_INIT_REL) begin
        line_oe_n_ff <= 1'b1;
      end else if (tx_go || state_ff == ST_TX_START && !tick) begin
        line_out_ff <= 1'b0;
      end else if (state_ff == ST_TX_START || state_ff == ST_TX_BITS) begin
        line_out_ff <= (state_ff == ST_TX_START) ? shreg_ff[0] :
                       ((tick && bit_cnt_ff == 4'(hdab_pkg::SHIFT_BITS - 1)) ? 1'b1 :
                        (tick ? shreg_ff[1] : line_out_ff));
      end
      if ((tick && (nxt_state == ST_RX_BITS || state_ff inside {ST_RX_START, ST_RX_BITS,
          ST_RX_STOP})) || (smp_cnt_ff > 2'h1)) begin
        line_oe_n_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      shift_en_ff <= 1'b1;
    end else begin
      shift_en_ff <= !(nxt_state == ST_REARM);
    end
  end

  // Frame error flags and received byte.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      serr_frame_ff <= 1'b0;
      perr_last_ff <= 1'b0;
      serr_last_ff <= 1'b0;
      rx_data_ff <= 8'h00;
    end else if (rx_go) begin
      serr_frame_ff <= 1'b0;
      perr_last_ff <= 1'b0;
      serr_last_ff <= 1'b0;
    end else if (state_ff == ST_RX_STOP && smp_now) begin
      serr_frame_ff <= fin_serr;
      if (rx_fin) begin
        perr_last_ff <= fin_perr;
        serr_last_ff <= fin_serr;
        rx_data_ff <= shreg_ff[7:0];
      end
    end
  end

  // Busy handshake and arming; the ninth received bit wins over a same-cycle toggle.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      busy_ff <= 1'b1;
      armed_ff <= 1'b0;
    end else if (rx_nine) begin
      busy_ff <= 1'b1;
      armed_ff <= 1'b0;
    end else if (bus_req_in.wr && hit(bus_req_in, hdab_pkg::OFS_CTRL) &&
                 bus_req_in.wdata[hdab_pkg::CTRL_TOGGLE]) begin
      busy_ff <= !busy_ff;
      armed_ff <= busy_ff;
    end
  end

  // Software-side data and control registers.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      odd_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      tx_pend_ff <= 1'b0;
      mask_ff <= hdab_pkg::MASK_RESET;
    end else begin
      if (tx_go) begin
        tx_pend_ff <= 1'b0;
      end
      if (bus_req_in.wr && hit(bus_req_in, hdab_pkg::OFS_CTRL)) begin
        odd_ff <= bus_req_in.wdata[hdab_pkg::CTRL_ODD];
      end
      if (bus_req_in.wr && hit(bus_req_in, hdab_pkg::OFS_TXDATA)) begin
        tx_data_ff <= bus_req_in.wdata[7:0];
        tx_pend_ff <= 1'b1;
      end
      if (bus_req_in.wr && hit(bus_req_in, hdab_pkg::OFS_MASK)) begin
        mask_ff <= bus_req_in.wdata[hdab_pkg::EV_BITS-1:0];
      end
    end
  end

  // Receive holding flag; a read of the byte frees it, a new byte sets it again.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rx_full_ff <= 1'b0;
    end else if (rx_fin && !fin_perr && !fin_serr) begin
      rx_full_ff <= 1'b1;
    end else if (bus_req_in.rd && hit(bus_req_in, hdab_pkg::OFS_RXDATA)) begin
      rx_full_ff <= 1'b0;
    end
  end

  // Event sources of the sticky status register.
  always_comb begin
    ev_set = '0;
    ev_set[hdab_pkg::EV_RX_DONE] = rx_fin && !fin_perr && !fin_serr;
    ev_set[hdab_pkg::EV_PARITY] = rx_fin && fin_perr;
    ev_set[hdab_pkg::EV_STOP] = rx_fin && fin_serr;
    ev_set[hdab_pkg::EV_OVERRUN] = rx_go && rx_full_ff;
    ev_set[hdab_pkg::EV_TX_DONE] = tx_fin;
    ev_clr = (bus_req_in.rd && hit(bus_req_in, hdab_pkg::OFS_STATUS)) ? '1 : '0;
  end

  // Set wins over the read-clear so an event in the reading cycle is kept.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // Read data stands one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (bus_req_in.rd) begin
        unique case (bus_req_in.addr)
          hdab_pkg::OFS_CTRL: rdata_ff <= 32'({armed_ff, busy_ff, odd_ff});
          hdab_pkg::OFS_TXDATA: rdata_ff <= 32'(tx_data_ff);
          hdab_pkg::OFS_RXDATA: rdata_ff <= 32'(rx_data_ff);
          hdab_pkg::OFS_STATUS: rdata_ff <= 32'({serr_last_ff, perr_last_ff, rx_full_ff,
                                                 tx_pend_ff || state_ff != ST_IDLE,
                                                 3'h0, status_ff});
          hdab_pkg::OFS_MASK: rdata_ff <= 32'(mask_ff);
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign rdata_out = rdata_ff;
  assign line_out = line_out_ff;
  assign line_oe_n_out = line_oe_n_ff;
  assign busy_out = busy_ff;
  assign irq_out = irq_ff;

  property p_tx_idle_peer;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_ff == ST_IDLE && nxt_state == ST_TX_START) |-> !busy_s;
  endproperty
  a_tx_idle_peer: assert property (p_tx_idle_peer) else $error("tx began with peer busy");

  property p_start_low;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_ff == ST_TX_START) |-> (!line_out_ff && !line_oe_n_ff);
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not driven low");

  property p_nine_bits;
    @(posedge ref_clk_in) disable iff (reset_in)
    $rose(state_ff == ST_TX_BITS) |-> (bit_cnt_ff == 4'h0) ##0
      (state_ff == ST_TX_BITS && bit_cnt_ff != 4'h9) [*1] ##1 1'b1;
  endproperty
  a_nine_bits: assert property (p_nine_bits) else $error("bad bit count at data start");

  property p_start_reject;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_ff == ST_RX_START && smp_now && line_s) |=> (state_ff == ST_IDLE);
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("high start accepted");

  property p_sample_released;
    @(posedge ref_clk_in) disable iff (reset_in)
    smp_now |-> $past(line_oe_n_ff, 2) && line_oe_n_ff ##1 !line_oe_n_ff;
  endproperty
  a_sample_released: assert property (p_sample_released) else $error("sampled while driving");

  property p_rearm;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_ff == ST_REARM) |-> !shift_en_ff ##1 shift_en_ff;
  endproperty
  a_rearm: assert property (p_rearm) else $error("shifter not restarted");

  property p_parity_gen;
    @(posedge ref_clk_in) disable iff (reset_in)
    tx_go |=> (shreg_ff[8] == ((^$past(tx_data_ff)) ^ $past(odd_ff)));
  endproperty
  a_parity_gen: assert property (p_parity_gen) else $error("wrong tx parity");

  property p_busy_nine;
    @(posedge ref_clk_in) disable iff (reset_in)
    rx_nine |=> busy_ff && !armed_ff;
  endproperty
  a_busy_nine: assert property (p_busy_nine) else $error("busy not raised after nine bits");

  property p_done_clean;
    @(posedge ref_clk_in) disable iff (reset_in)
    (rx_fin && (fin_perr || fin_serr)) |=> !$rose(status_ff[hdab_pkg::EV_RX_DONE]);
  endproperty
  a_done_clean: assert property (p_done_clean) else $error("done set on bad frame");

  c_tx_frame: cover property (@(posedge ref_clk_in) disable iff (reset_in) tx_fin);
  c_rx_clean: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    rx_fin && !fin_perr && !fin_serr);
  c_rx_perr: cover property (@(posedge ref_clk_in) disable iff (reset_in) rx_fin && fin_perr);
  c_overrun: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    ev_set[hdab_pkg::EV_OVERRUN]);

endmodule

// File: hdab_peer.sv
// Far-side node model that sends one frame on request and reports its busy level.
`timescale 1ns/10ps
module hdab_peer #(
  parameter int unsigned T = 108
) (
  // Clock.
  input wire logic ref_clk_in,
  // Frame request and the device's busy level.
  input wire logic send_in,
  input wire logic [10:0] bits_in,
  input wire logic dev_busy_in,
  input wire logic busy_req_in,
  // Line level and busy level towards the device.
  output logic line_out,
  output logic busy_out
);
  logic [11:0] sh_ff = 12'hfff;
  logic [3:0] left_ff = 4'h0;
  int unsigned cnt_ff = 0;

  // An idle or finished shifter holds all ones, which stands for the line pull-up.
  assign line_out = sh_ff[0];

  // ready-gated send.
  // A request is dropped while the device is busy; bits leave LSB first, parity, two stops.
  always @(posedge ref_clk_in) begin
    busy_out <= busy_req_in;
    if (left_ff == 4'h0) begin
      if (send_in && !dev_busy_in) begin
        sh_ff <= {bits_in, 1'b0};
        left_ff <= 4'hc;
        cnt_ff <= T;
      end
    end else if (cnt_ff == 1) begin
      sh_ff <= {1'b1, sh_ff[11:1]};
      left_ff <= left_ff - 4'h1;
      cnt_ff <= T;
    end else begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the half-duplex busy link.
`timescale 1ns/10ps
module tb;
  localparam int unsigned PS = 2;
  localparam int unsigned T = PS * hdab_pkg::TIMER_COMPARE;
  logic ref_clk_in, reset_in, line_out, oe_n, busy_out, irq_out, peer_lvl, peer_busy;
  logic line_lvl, send, pbusy, glitch;
  hdab_pkg::hdab_bus_req_s req;
  logic [31:0] rdata, rnd, rv;
  logic [10:0] pbits;
  logic [4:0] est [5] = '{5'h01, 5'h02, 5'h04, 5'h01, 5'h09};
  int errors, checks, n;

  // The device wins while it drives; released, the wire follows the peer.
  assign line_lvl = oe_n ? peer_lvl : line_out;

  hdab_link #(.PRESCALE(PS)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .bus_req_in(req), .rdata_out(rdata), .line_in(line_lvl), .line_out(line_out),
    .line_oe_n_out(oe_n), .peer_busy_in(peer_busy), .start_edge_input_in(peer_lvl && !glitch),
    .busy_out(busy_out), .irq_out(irq_out));
  hdab_peer #(.T(T)) peer (.ref_clk_in(ref_clk_in), .send_in(send), .bits_in(pbits),
    .dev_busy_in(busy_out), .busy_req_in(pbusy), .line_out(peer_lvl), .busy_out(peer_busy));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic tx_frame(input logic [7:0] d, input logic odd);
    // Busy goes up first so its synchronised level is high before the byte is pending.
    @(posedge ref_clk_in);
    pbusy <= 1'b1;
    bus_wr(hdab_pkg::OFS_CTRL, {31'h0, odd});
    bus_wr(hdab_pkg::OFS_TXDATA, {24'h0, d});
    repeat (2 * T) @(negedge ref_clk_in);
    cmp("tx held", 1, line_out);
    pbusy <= 1'b0;
    n = 0;
    while (line_out !== 1'b0 && n < 4 * T) begin
      @(negedge ref_clk_in);
      n++;
    end
    repeat (T / 2) @(negedge ref_clk_in);
    cmp("start", 0, line_out);
    for (int i = 0; i < 11; i++) begin
      repeat (T) @(negedge ref_clk_in);
      cmp("tx bit", i < 8 ? d[i] : (i == 8 ? ^d ^ odd : 1'b1), line_out);
    end
    repeat (T) @(negedge ref_clk_in);
    cmp("tx irq", 1, irq_out);
    bus_rd(hdab_pkg::OFS_STATUS, rv);
    cmp("tx status", 5'h10, rv[4:0]);
  endtask

  // The peer sends one frame; bad parity or a low first stop are injected on demand.
  task automatic rx_frame(input logic [7:0] d, input logic odd, input logic bp,
                          input logic bs, input logic [4:0] e, input logic rdd);
    bus_wr(hdab_pkg::OFS_CTRL, {30'h0, 1'b1, odd});
    repeat (2) @(negedge ref_clk_in);
    cmp("busy low", 0, busy_out);
    // A short dip on the start input while the line stays high must not start a frame.
    if (rdd) begin
      @(posedge ref_clk_in);
      glitch <= 1'b1;
      @(posedge ref_clk_in);
      glitch <= 1'b0;
      repeat (T) @(negedge ref_clk_in);
      bus_rd(hdab_pkg::OFS_STATUS, rv);
      cmp("glitch idle", 0, rv[hdab_pkg::ST_TX_BUSY]);
    end
    @(posedge ref_clk_in);
    pbits <= {1'b1, ~bs, ^d ^ odd ^ bp, d};
    send <= 1'b1;
    @(posedge ref_clk_in);
    send <= 1'b0;
    n = 0;
    while (busy_out !== 1'b1 && n < 12 * T) begin
      @(negedge ref_clk_in);
      n++;
    end
    cmp("busy high", 1, busy_out);
    repeat (3 * T) @(negedge ref_clk_in);
    cmp("rx irq", 1, irq_out);
    bus_rd(hdab_pkg::OFS_STATUS, rv);
    cmp("rx status", e, rv[4:0]);
    if (rdd) begin
      bus_rd(hdab_pkg::OFS_RXDATA, rv);
      cmp("rx data", d, rv[7:0]);
    end
    repeat (3) @(negedge ref_clk_in);
    cmp("irq clear", 0, irq_out);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Free-running device clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // A frame takes 12 bit periods on the line; the limit leaves ample room for eight of them.
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    errors++;
    $display("mismatch watchdog expected end seen hang");
    tally_and_finish();
  end

  // Main sequence: reset, registers, three transmits, five receptions.
  initial begin
    reset_in = 1'b1;
    req = '0;
    send = 1'b0;
    glitch = 1'b0;
    pbusy = 1'b0;
    pbits = 11'h7ff;
    rnd = 32'h000042a7;
    repeat (3) @(posedge ref_clk_in);
    #1;
    cmp("reset line", 1, line_out);
    cmp("reset busy", 1, busy_out);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    n = 0;
    repeat (6) begin
      @(negedge ref_clk_in);
      n += oe_n;
    end
    cmp("init release", 1, 32'(n));
    bus_wr(hdab_pkg::OFS_MASK, 32'h1f);
    bus_rd(hdab_pkg::OFS_MASK, rv);
    cmp("mask", 32'h1f, rv);
    bus_rd(8'h14, rv);
    cmp("unmapped", 0, rv);
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      tx_frame(k == 2 ? 8'hff : rnd[7:0], k[0]);
    end
    for (int k = 0; k < 5; k++) begin
      rnd = xs(rnd);
      rx_frame(rnd[7:0], rnd[8], k == 1, k == 2, est[k], k == 0);
    end
    tally_and_finish();
  end
endmodule
